// [core/fault_timer.sv]
// Functional notes
// R1: Count field decrements once every 12288 clocks; 64 timeout steps.
// R2: Active and count 40h to 3Fh starts a 500 ns reset pulse.
// R3: Software refreshes periodically with C0h..FFh.
// R4: Deactivated after any reset; only reset deactivates it.
// R5: Write with activation set and top bit clear forces reset.
// R6: Hardware watchdog option keeps it always active.
// R7: Wait state has no effect on counting or reset.
// R8: Reset-on-halt option plus active: halt gives immediate reset.
// R9: Plain halt freezes count and suppresses reset until wake.
// R10: Interrupt wake resumes counting after 4096 clocks; reset wake deactivates.
// R11: Control register: activation bit 7, count bits 6..0, reset 7Fh.
// R12: Software may set activation; only hardware reset clears it.
// R13: At 8 MHz, FFh gives 98.304 ms, C0h 1.536 ms.
// R14: Software should refresh the count just before halting.
// R15: Write loads count directly; activation may be set, never cleared.
`timescale 1ns/1ps
`default_nettype none
module fault_timer
#(
   parameter int unsigned PRESCALE = fault_timer_pkg::PRESCALE_CYCLES,
   parameter int unsigned WAKE_DELAY = fault_timer_pkg::WAKE_CYCLES
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic write_i,
   input wire logic read_i,
   output logic [7:0] rdata_o,
   // Option byte and power states
   input wire logic hw_watchdog_i,
   input wire logic reset_on_halt_i,
   input wire logic wait_i,
   input wire logic halt_i,
   input wire logic ext_wake_i,
   // Reset request and activation status
   output logic reset_n_o,
   output logic activated_o
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [1:0] {RUNNING, HALTED, WAKING} power_e;

   power_e power;
   power_e next_power;
   logic activation;
   logic [6:0] count;
   logic [12:0] wake_count;
   logic [5:0] pulse_count;
   logic [6:0] low_run;
   logic tick;
   logic active;
   logic ctrl_write;
   logic rolls_over;
   logic soft_reset;
   logic halt_reset;
   logic fire;

   function automatic logic is_control(input logic [7:0] addr);
      is_control = (addr == fault_timer_pkg::ADDR_CONTROL);
   endfunction

   assign ctrl_write = write_i && is_control(addr_i);
   // Option byte overrides the software bit
   assign active = activation || hw_watchdog_i; // R6
   // Wait is not looked at: counting carries on through it
   // A refresh in the same cycle wins over the rollover
   assign rolls_over = tick && !ctrl_write
                       && (count == fault_timer_pkg::COUNT_ROLL_FROM); // R2 R7
   assign soft_reset = ctrl_write && (wdata_i[fault_timer_pkg::ACTIVATION_POS] || active)
                       && !wdata_i[fault_timer_pkg::TOP_POS]; // R5
   assign halt_reset = halt_i && reset_on_halt_i && active && (power == RUNNING); // R8
   // Software reset carries its own activation, so it also fires from the inactive state
   assign fire = ((active && rolls_over) || soft_reset || halt_reset)
                 && (power == RUNNING); // R2 R5 R8

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   // Cleared on refresh so every timeout step is whole
   fault_timer_divider #(
      .PERIOD(PRESCALE)
   ) u_divider (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .run_i(power == RUNNING),
      .clear_i(ctrl_write),
      .tick_o(tick)
   ); // R1 R9 R13

   // ----------------------------------------
   // Halt tracking
   // ----------------------------------------
   always_comb
   begin
      next_power = power;
      case (power)
         RUNNING:
            if (halt_i && !(reset_on_halt_i && active))
            begin
               next_power = HALTED; // R9
            end
         HALTED:
            if (ext_wake_i)
            begin
               next_power = WAKING; // R10
            end
         WAKING:
            if (wake_count == 13'(WAKE_DELAY - 1))
            begin
               next_power = RUNNING; // R10
            end
         default:
            next_power = RUNNING;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power <= RUNNING;
      end
      else
      begin
         power <= next_power;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_count <= 13'h0000;
      end
      else if (power == WAKING)
      begin
         wake_count <= wake_count + 13'h0001; // R10
      end
      else
      begin
         wake_count <= 13'h0000;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         activation <= fault_timer_pkg::CONTROL_RESET[7]; // R4 R11
         count <= fault_timer_pkg::CONTROL_RESET[6:0]; // R11
      end
      else
      begin
         if (ctrl_write)
         begin
            // Only ever set here; a reset is the sole way back to zero
            activation <= activation | wdata_i[fault_timer_pkg::ACTIVATION_POS]; // R12 R15 R4
            count <= wdata_i[6:0]; // R15
         end
         else if (tick && power == RUNNING)
         begin
            // A tick caught on the way into halt is dropped
            count <= count - 7'h01; // R1 R9
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_o <= 8'h00;
      end
      else if (read_i && is_control(addr_i))
      begin
         rdata_o <= {activation, count}; // R11
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         activated_o <= 1'b0;
      end
      else
      begin
         activated_o <= active;
      end
   end

   // ----------------------------------------
   // Reset pulse
   // ----------------------------------------
   // Pulse may outlive its cause; the system reset ends it anyway
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulse_count <= 6'h00;
         reset_n_o <= 1'b1;
      end
      else if (fire && pulse_count == 6'h00)
      begin
         pulse_count <= 6'(fault_timer_pkg::PULSE_CYCLES); // R2
         reset_n_o <= 1'b0; // R2 R5 R8
      end
      else if (pulse_count > 6'h01)
      begin
         pulse_count <= pulse_count - 6'h01;
      end
      else
      begin
         pulse_count <= 6'h00;
         reset_n_o <= 1'b1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Low stretch length; a counter, since the pulse is too long for a repetition
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_run <= 7'h00;
      end
      else if (!reset_n_o)
      begin
         low_run <= low_run + 7'h01;
      end
      else
      begin
         low_run <= 7'h00;
      end
   end

   sequence s_roll;
      active && rolls_over && power == RUNNING && pulse_count == 6'h00;
   endsequence

   sequence s_pulse_end;
      $rose(reset_n_o);
   endsequence

   sequence s_read;
      read_i && is_control(addr_i);
   endsequence

   AST_ROLL_RESET: assert property (@(posedge clock_i) disable iff (!rst_n) // R2
      s_roll |=> !reset_n_o [*8])
      else $error("Rollover did not start a reset pulse");

   AST_PULSE_WIDTH: assert property (@(posedge clock_i) disable iff (!rst_n) // R2
      s_pulse_end |-> low_run == 7'(fault_timer_pkg::PULSE_CYCLES))
      else $error("Reset pulse width is not 500 ns");

   AST_SOFT_RESET: assert property (@(posedge clock_i) disable iff (!rst_n) // R5
      soft_reset && power == RUNNING && pulse_count == 6'h00 |=> !reset_n_o)
      else $error("Software reset write gave no pulse");

   AST_HALT_RESET: assert property (@(posedge clock_i) disable iff (!rst_n) // R8
      halt_reset && pulse_count == 6'h00 |=> !reset_n_o)
      else $error("Halt with reset option gave no pulse");

   AST_NO_DEACTIVATE: assert property (@(posedge clock_i) disable iff (!rst_n) // R4 R12
      activation |=> activation)
      else $error("Activation bit cleared without reset");

   AST_SET_ONLY: assert property (@(posedge clock_i) disable iff (!rst_n) // R12 R15
      ctrl_write && wdata_i[fault_timer_pkg::ACTIVATION_POS] |=> activation)
      else $error("Write did not set the activation bit");

   AST_INACTIVE_QUIET: assert property (@(posedge clock_i) disable iff (!rst_n) // R4
      !active && !soft_reset && pulse_count == 6'h00 |=> reset_n_o)
      else $error("Reset pulse while deactivated");

   // Release edge still clears the output flop, so wait for the settled reset
   AST_HW_OPTION: assert property (@(posedge clock_i) disable iff (!rst_n) // R6
      hw_watchdog_i && rst_n |=> activated_o)
      else $error("Hardware option did not force activation");

   AST_HALT_FREEZE: assert property (@(posedge clock_i) disable iff (!rst_n) // R9
      power == HALTED && !ctrl_write |=> $stable(count) && reset_n_o)
      else $error("Counter moved or reset fired while halted");

   AST_WAKE_DELAY: assert property (@(posedge clock_i) disable iff (!rst_n) // R10
      power == HALTED && ext_wake_i |=> power == WAKING [*8])
      else $error("Counting resumed too early after wake");

   AST_WAKE_FROZEN: assert property (@(posedge clock_i) disable iff (!rst_n) // R10
      power == WAKING && !ctrl_write |=> $stable(count))
      else $error("Counter moved during the wake delay");

   AST_WAKE_QUIET: assert property (@(posedge clock_i) disable iff (!rst_n) // R9 R10
      power != RUNNING && pulse_count == 6'h00 |=> reset_n_o)
      else $error("Reset pulse while halted or waking");

   AST_WRITE_LOAD: assert property (@(posedge clock_i) disable iff (!rst_n) // R15
      ctrl_write |=> count == $past(wdata_i[6:0]))
      else $error("Write did not load the count");

   AST_READ_DATA: assert property (@(posedge clock_i) disable iff (!rst_n) // R11
      s_read |=> rdata_o == $past({activation, count}))
      else $error("Read data does not match the control register");

   AST_READ_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n) // R11
      !(read_i && is_control(addr_i)) |=> rdata_o == 8'h00)
      else $error("Read data not zero outside a control read");

   AST_DECREMENT: assert property (@(posedge clock_i) disable iff (!rst_n) // R1 R7
      tick && !ctrl_write && power == RUNNING |=> count == $past(count) - 7'h01)
      else $error("Count did not step down on a tick");
endmodule
`default_nettype wire

// [core/fault_timer_pkg.sv]
package fault_timer_pkg;
   // --------------------------------
   // Register map
   // --------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'h24;
   localparam logic [7:0] CONTROL_RESET = 8'h7f;
   localparam int ACTIVATION_POS = 7;
   localparam int TOP_POS = 6;
   localparam logic [6:0] COUNT_ROLL_FROM = 7'h40;

   // --------------------------------
   // Timing
   // --------------------------------
   localparam int CLOCK_MHZ = 100;
   localparam int PRESCALE_CYCLES = 12288;
   localparam int WAKE_CYCLES = 4096;
   localparam int PULSE_NS = 500;
   localparam int PULSE_CYCLES = (PULSE_NS * CLOCK_MHZ + 999) / 1000;
endpackage

// [core/fault_timer_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module fault_timer_divider
#(
   parameter int unsigned PERIOD = 12288
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Control
   input wire logic run_i,
   input wire logic clear_i,
   // Tick
   output logic tick_o
);
   logic [15:0] count;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count <= 16'h0000;
         tick_o <= 1'b0;
      end
      else if (clear_i)
      begin
         count <= 16'h0000;
         tick_o <= 1'b0;
      end
      else if (run_i)
      begin
         if (count == 16'(PERIOD - 1))
         begin
            count <= 16'h0000;
            tick_o <= 1'b1;
         end
         else
         begin
            count <= count + 16'h0001;
            tick_o <= 1'b0;
         end
      end
      else
      begin
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   // Short counts keep the run brief; the timeout and wake expectations use them
   localparam int P = 16;
   localparam int WK = 40;
   localparam int PW = fault_timer_pkg::PULSE_CYCLES;
   logic clock_i, rst_n_i, write_i, read_i, hw_i, roh_i, wait_i, halt_i, wake_i;
   logic [7:0] addr_i, wdata_i, rdata_o, ctl;
   logic reset_n_o, activated_o, low_seen;
   int fail_count, n_checks, k;

   fault_timer #(.PRESCALE(P), .WAKE_DELAY(WK)) fault_timer_i (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .hw_watchdog_i(hw_i),
      .reset_on_halt_i(roh_i), .wait_i(wait_i), .halt_i(halt_i), .ext_wake_i(wake_i),
      .reset_n_o(reset_n_o), .activated_o(activated_o));

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // ----------------------------------------
   // Compare and bus tasks
   // ----------------------------------------
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_count(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Stands in for the system reset that the request line would cause
   task automatic do_reset();
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      ctl = 8'h7f;
   endtask

   task automatic wr(input logic [7:0] v);
      @(posedge clock_i);
      addr_i <= 8'h24;
      wdata_i <= v;
      write_i <= 1'b1;
      @(posedge clock_i);
      write_i <= 1'b0;
      ctl = {ctl[7] | v[7], v[6:0]};
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      read_i <= 1'b1;
      @(posedge clock_i);
      read_i <= 1'b0;
      #1 check_byte(rdata_o, exp);
   endtask

   task automatic pulse(input bit h);
      @(posedge clock_i);
      if (h)
         halt_i <= 1'b1;
      else
         wake_i <= 1'b1;
      @(posedge clock_i);
      halt_i <= 1'b0;
      wake_i <= 1'b0;
   endtask

   // Cycles until the request falls, then its width, then a fresh reset
   task automatic fire(input int lo, input int hi);
      int n;
      int m;
      n = 0;
      m = 0;
      #1;
      while (reset_n_o === 1'b1 && n <= hi + 4)
      begin
         @(posedge clock_i);
         #1 n++;
      end
      check_count(n, lo, hi);
      if (n > hi + 4)
         conclude();
      while (reset_n_o !== 1'b1 && m < 200)
      begin
         @(posedge clock_i);
         #1 m++;
      end
      check_count(m, PW, PW);
      do_reset();
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst_n_i, write_i, read_i, hw_i, roh_i, wait_i, halt_i, wake_i} = '0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      fail_count = 0;
      n_checks = 0;
      ctl = 8'h7f;
      void'($urandom(63));
      do_reset();
      rd(8'h24, 8'h7f);
      check_byte({7'h00, activated_o}, 8'h00);
      rd(8'h25, 8'h00);
      wr(8'h3f);
      #1 check_byte({7'h00, reset_n_o}, 8'h01);
      rd(8'h24, ctl);
      wr(8'hc0 | 8'($urandom_range(63, 0)));
      wr(8'h7f);
      rd(8'h24, ctl);
      check_byte({7'h00, activated_o}, 8'h01);
      fire(64 * P - 1, 64 * P + 3);
      for (int i = 0; i < 4; i++)
      begin
         k = (i == 0) ? 0 : $urandom_range(63, 0);
         @(posedge clock_i);
         wait_i <= 1'($urandom_range(1, 0));
         wr(8'hc0 | 8'(k));
         fire((k + 1) * P - 1, (k + 1) * P + 3);
      end
      wait_i <= 1'b0;
      wr(8'h80 | 8'($urandom_range(63, 0)));
      fire(0, 3);
      hw_i <= 1'b1;
      do_reset();
      repeat (2) @(posedge clock_i);
      #1 check_byte({7'h00, activated_o}, 8'h01);
      wr(8'h3f);
      fire(0, 3);
      hw_i <= 1'b0;
      roh_i <= 1'b1;
      do_reset();
      pulse(1'b1);
      repeat (3) @(posedge clock_i);
      #1 check_byte({7'h00, reset_n_o}, 8'h01);
      pulse(1'b0);
      repeat (WK + 5) @(posedge clock_i);
      wr(8'hff);
      pulse(1'b1);
      fire(0, 3);
      roh_i <= 1'b0;
      wr(8'hc1);
      pulse(1'b1);
      low_seen = 1'b0;
      repeat (4 * P)
      begin
         @(posedge clock_i);
         #1 low_seen = low_seen | (reset_n_o !== 1'b1);
      end
      check_byte({7'h00, low_seen}, 8'h00);
      pulse(1'b0);
      fire(WK + P + 1, WK + 2 * P + 3);
      check_byte({7'h00, activated_o}, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
